// *** rtl/energy_pulse_output.sv ***
// Two digital frequency converters driving active-low calibration pulses.
// Assumes energy LSB strobes and register strobes come from the same clock.
`timescale 1ns/1ps
module energy_pulse_output #(
  parameter int LOW_HOLD_CYCLES = energy_pulse_pkg::LOW_HOLD_CYCLES,
  parameter int LONG_PERIOD_CYC = energy_pulse_pkg::LONG_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  // Energy LSB strobes from the metering datapath
  input  wire logic        active_lsb_in,
  input  wire logic        reactive_lsb_in,
  input  wire logic        apparent_lsb_in,
  input  wire logic        rms_lsb_in,
  // Register port: meter_space_in selects metering registers over SFRs
  input  wire logic        meter_space_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [15:0] reg_rdata_out,
  // Calibration pulses and interrupt
  output logic             pulse_out1_n_out,
  output logic             pulse_out2_n_out,
  output logic             meter_irq_out,
  output logic      [15:0] irq_vector_out
);

  logic [7:0]  cfg1_q, cfg1_d;
  logic [7:0]  cfg2_q, cfg2_d;
  logic [7:0]  en_low_q, en_low_d;
  logic [7:0]  en_mid_q, en_mid_d;
  logic [7:0]  en_high_q, en_high_d;
  logic [7:0]  st_mid_q, st_mid_d;
  logic [15:0] num_q [2];
  logic [15:0] num_d [2];
  logic [15:0] den_q [2];
  logic [15:0] den_d [2];
  logic [15:0] rdata_q, rdata_d;
  logic        irq_q, irq_d;
  logic [1:0]  pulse_start;
  logic [1:0]  pulse_n;
  logic [1:0]  out_disable;
  logic        sfr_wr;
  logic        met_wr;

  assign sfr_wr = reg_wr_in && !meter_space_in;
  assign met_wr = reg_wr_in && meter_space_in;
  assign out_disable[0] = cfg1_q[energy_pulse_pkg::OUT1_DISABLE_BIT];
  assign out_disable[1] = cfg1_q[energy_pulse_pkg::OUT2_DISABLE_BIT];

  // Register writes, status flags and read data.
  always_comb begin
    cfg1_d    = cfg1_q;
    cfg2_d    = cfg2_q;
    en_low_d  = en_low_q;
    en_mid_d  = en_mid_q;
    en_high_d = en_high_q;
    st_mid_d  = st_mid_q;
    num_d     = num_q;
    den_d     = den_q;
    rdata_d   = rdata_q;
    if (met_wr) begin
      case (reg_addr_in)
        energy_pulse_pkg::MEAS_CFG_FIRST_ADDR:  cfg1_d = reg_wdata_in[7:0];
        energy_pulse_pkg::MEAS_CFG_SECOND_ADDR: cfg2_d = reg_wdata_in[7:0];
        energy_pulse_pkg::NUM1_ADDR:            num_d[0] = reg_wdata_in;
        energy_pulse_pkg::DEN1_ADDR:            den_d[0] = reg_wdata_in;
        energy_pulse_pkg::NUM2_ADDR:            num_d[1] = reg_wdata_in;
        energy_pulse_pkg::DEN2_ADDR:            den_d[1] = reg_wdata_in;
        default: ;
      endcase
    end
    if (sfr_wr) begin
      case (reg_addr_in)
        energy_pulse_pkg::IRQ_EN_LOW_ADDR:  en_low_d  = reg_wdata_in[7:0];
        energy_pulse_pkg::IRQ_EN_MID_ADDR:  en_mid_d  = reg_wdata_in[7:0];
        energy_pulse_pkg::IRQ_EN_HIGH_ADDR: en_high_d = reg_wdata_in[7:0];
        // Writing a zero clears a flag; a one leaves it alone.
        energy_pulse_pkg::IRQ_ST_MID_ADDR:
          st_mid_d = st_mid_q & reg_wdata_in[7:0];
        default: ;
      endcase
    end
    // Hardware set is applied after the clear so a same-cycle event wins.
    if (pulse_start[0] && !out_disable[0]) begin
      st_mid_d[energy_pulse_pkg::FLAG1_BIT] = 1'b1;
    end
    if (pulse_start[1] && !out_disable[1]) begin
      st_mid_d[energy_pulse_pkg::FLAG2_BIT] = 1'b1;
    end
    // Only the enabled flags reach the core.
    irq_d = |(st_mid_q & en_mid_q);
    if (reg_rd_in) begin
      rdata_d = energy_pulse_pkg::REG16_RESET;
      if (meter_space_in) begin
        case (reg_addr_in)
          energy_pulse_pkg::MEAS_CFG_FIRST_ADDR:  rdata_d[7:0] = cfg1_q;
          energy_pulse_pkg::MEAS_CFG_SECOND_ADDR: rdata_d[7:0] = cfg2_q;
          energy_pulse_pkg::NUM1_ADDR:            rdata_d = num_q[0];
          energy_pulse_pkg::DEN1_ADDR:            rdata_d = den_q[0];
          energy_pulse_pkg::NUM2_ADDR:            rdata_d = num_q[1];
          energy_pulse_pkg::DEN2_ADDR:            rdata_d = den_q[1];
          default: ;
        endcase
      end else begin
        case (reg_addr_in)
          energy_pulse_pkg::IRQ_EN_LOW_ADDR:  rdata_d[7:0] = en_low_q;
          energy_pulse_pkg::IRQ_EN_MID_ADDR:  rdata_d[7:0] = en_mid_q;
          energy_pulse_pkg::IRQ_EN_HIGH_ADDR: rdata_d[7:0] = en_high_q;
          energy_pulse_pkg::IRQ_ST_MID_ADDR:  rdata_d[7:0] = st_mid_q;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg1_q    <= energy_pulse_pkg::REG8_RESET;
      cfg2_q    <= energy_pulse_pkg::REG8_RESET;
      en_low_q  <= energy_pulse_pkg::REG8_RESET;
      en_mid_q  <= energy_pulse_pkg::REG8_RESET;
      en_high_q <= energy_pulse_pkg::REG8_RESET;
      st_mid_q  <= energy_pulse_pkg::REG8_RESET;
      num_q[0]  <= energy_pulse_pkg::REG16_RESET;
      num_q[1]  <= energy_pulse_pkg::REG16_RESET;
      den_q[0]  <= energy_pulse_pkg::REG16_RESET;
      den_q[1]  <= energy_pulse_pkg::REG16_RESET;
      rdata_q   <= energy_pulse_pkg::REG16_RESET;
      irq_q     <= 1'b0;
    end else begin
      cfg1_q    <= cfg1_d;
      cfg2_q    <= cfg2_d;
      en_low_q  <= en_low_d;
      en_mid_q  <= en_mid_d;
      en_high_q <= en_high_d;
      st_mid_q  <= st_mid_d;
      num_q     <= num_d;
      den_q     <= den_d;
      rdata_q   <= rdata_d;
      irq_q     <= irq_d;
    end
  end

  // Per-converter datapath.
  for (genvar ch = 0; ch < 2; ch++) begin : g_conv
    localparam int SEL_LSB = (ch == 0) ? energy_pulse_pkg::SEL1_LSB
                                       : energy_pulse_pkg::SEL2_LSB;
    logic [1:0]  sel;
    logic        lsb_strobe;
    logic [15:0] num_eff;
    logic [15:0] den_eff;
    logic [16:0] acc_sum;
    logic [16:0] acc_q, acc_d;
    logic [energy_pulse_pkg::TIMER_W-1:0] period_q, period_d;
    logic [energy_pulse_pkg::TIMER_W-1:0] low_q, low_d;
    logic [energy_pulse_pkg::TIMER_W-1:0] half_per;
    energy_pulse_pkg::pulse_state_t state_q, state_d;
    logic        out_n_q, out_n_d;
    logic        fire;

    assign sel = cfg2_q[SEL_LSB +: 2];
    always_comb begin
      case (sel)
        energy_pulse_pkg::SEL_ACTIVE:   lsb_strobe = active_lsb_in;
        energy_pulse_pkg::SEL_REACTIVE: lsb_strobe = reactive_lsb_in;
        // One shared bit, so both outputs see the same choice.
        default: lsb_strobe = cfg2_q[energy_pulse_pkg::RMS_SUB_BIT]
                            ? rms_lsb_in : apparent_lsb_in;
      endcase
    end

    // Zero acts as one, and the ratio never exceeds one.
    always_comb begin
      den_eff = (den_q[ch] == energy_pulse_pkg::REG16_RESET)
              ? energy_pulse_pkg::RATIO_ONE : den_q[ch];
      num_eff = (num_q[ch] == energy_pulse_pkg::REG16_RESET)
              ? energy_pulse_pkg::RATIO_ONE : num_q[ch];
      if (num_eff > den_eff) begin
        num_eff = den_eff;
      end
    end

    // Each strobe adds the numerator; reaching the denominator fires.
    assign acc_sum = acc_q + {1'b0, num_eff};
    assign fire = lsb_strobe && (acc_sum >= {1'b0, den_eff});
    assign half_per = period_q >> 1;

    always_comb begin
      acc_d    = acc_q;
      period_d = period_q;
      low_d    = low_q;
      state_d  = state_q;
      out_n_d  = out_n_q;
      if (lsb_strobe) begin
        acc_d = fire ? (acc_sum - {1'b0, den_eff}) : acc_sum;
      end
      // The period count saturates at the long-period threshold.
      if (period_q < energy_pulse_pkg::TIMER_W'(LONG_PERIOD_CYC)) begin
        period_d = period_q + energy_pulse_pkg::TIMER_W'(1);
      end
      case (state_q)
        energy_pulse_pkg::PULSE_IDLE: begin
          out_n_d = 1'b1;
        end
        energy_pulse_pkg::PULSE_LOW: begin
          if (low_q <= energy_pulse_pkg::TIMER_W'(1)) begin
            state_d = energy_pulse_pkg::PULSE_IDLE;
            out_n_d = 1'b1;
          end else begin
            low_d = low_q - energy_pulse_pkg::TIMER_W'(1);
          end
        end
        default: begin
          state_d = energy_pulse_pkg::PULSE_IDLE;
          out_n_d = 1'b1;
        end
      endcase
      if (fire) begin
        // The low time follows the period just ended; a new pulse restarts it.
        period_d = energy_pulse_pkg::TIMER_W'(1);
        if (period_q >= energy_pulse_pkg::TIMER_W'(LONG_PERIOD_CYC)) begin
          low_d = energy_pulse_pkg::TIMER_W'(LOW_HOLD_CYCLES);
        end else if (half_per == '0) begin
          low_d = energy_pulse_pkg::TIMER_W'(1);
        end else begin
          low_d = half_per;
        end
        if (!out_disable[ch]) begin
          state_d = energy_pulse_pkg::PULSE_LOW;
          out_n_d = 1'b0;
        end
      end
      if (out_disable[ch]) begin
        state_d = energy_pulse_pkg::PULSE_IDLE;
        out_n_d = 1'b1;
      end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        acc_q    <= '0;
        period_q <= '0;
        low_q    <= '0;
        state_q  <= energy_pulse_pkg::PULSE_IDLE;
        out_n_q  <= 1'b1;
      end else begin
        acc_q    <= acc_d;
        period_q <= period_d;
        low_q    <= low_d;
        state_q  <= state_d;
        out_n_q  <= out_n_d;
      end
    end

    assign pulse_start[ch] = fire;
    assign pulse_n[ch] = out_n_q;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_vector_out <= energy_pulse_pkg::METER_IRQ_VECTOR;
    end else begin
      irq_vector_out <= energy_pulse_pkg::METER_IRQ_VECTOR;
    end
  end

  assign pulse_out1_n_out = pulse_n[0];
  assign pulse_out2_n_out = pulse_n[1];
  assign meter_irq_out    = irq_q;
  assign reg_rdata_out    = rdata_q;

endmodule

// *** rtl/energy_pulse_pkg.sv ***
// Constants for the energy to frequency pulse output block.
// Assumes a 25 MHz metering clock and 8/16-bit register ports.
package energy_pulse_pkg;
  // Metering register offsets, in the metering register space.
  localparam logic [7:0] MEAS_CFG_FIRST_ADDR  = 8'h0b;
  localparam logic [7:0] MEAS_CFG_SECOND_ADDR = 8'h0c;
  localparam logic [7:0] NUM1_ADDR            = 8'h27;
  localparam logic [7:0] DEN1_ADDR            = 8'h28;
  localparam logic [7:0] NUM2_ADDR            = 8'h29;
  localparam logic [7:0] DEN2_ADDR            = 8'h2a;
  // Special function register offsets.
  localparam logic [7:0] IRQ_EN_LOW_ADDR      = 8'hd9;
  localparam logic [7:0] IRQ_EN_MID_ADDR      = 8'hda;
  localparam logic [7:0] IRQ_EN_HIGH_ADDR     = 8'hdb;
  localparam logic [7:0] IRQ_ST_MID_ADDR      = 8'hdd;
  // Field positions.
  localparam int OUT1_DISABLE_BIT = 1;
  localparam int OUT2_DISABLE_BIT = 2;
  localparam int RMS_SUB_BIT      = 3;
  localparam int SEL1_LSB         = 4;
  localparam int SEL2_LSB         = 6;
  localparam int FLAG1_BIT        = 6;
  localparam int FLAG2_BIT        = 7;
  // Reset values and the unit ratio.
  localparam logic [7:0]  REG8_RESET  = 8'h00;
  localparam logic [15:0] REG16_RESET = 16'h0000;
  localparam logic [15:0] RATIO_ONE   = 16'h0001;
  // Interrupt vector of the metering events.
  localparam logic [15:0] METER_IRQ_VECTOR = 16'h004b;
  // Source select codes.
  localparam logic [1:0] SEL_ACTIVE   = 2'h0;
  localparam logic [1:0] SEL_REACTIVE = 2'h1;
  // Timing.
  localparam int CLK_KHZ          = 25000;
  localparam int LOW_HOLD_MS      = 90;
  localparam int LONG_PERIOD_MS   = 180;
  localparam int LOW_HOLD_CYCLES  = LOW_HOLD_MS * CLK_KHZ;
  localparam int LONG_PERIOD_CYC  = LONG_PERIOD_MS * CLK_KHZ;
  localparam int TIMER_W          = 23;
  // Output pulse state.
  typedef enum logic [0:0] {
    PULSE_IDLE = 1'b0,
    PULSE_LOW  = 1'b1
  } pulse_state_t;
endpackage

// *** sim/cal_equipment.sv ***
// Calibration equipment model: counts LED flashes and times each one.
// Assumes the pulse lines are sampled on the metering clock.
`timescale 1ns/1ps
module cal_equipment (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  // Pulse lines, low while the LED is lit
  input  wire logic pulse_out1_n_in,
  input  wire logic pulse_out2_n_in,
  // Flash counts and length of the last flash in cycles
  output int        count_out[2],
  output int        low_out[2]
);
  int         run[2];
  logic [1:0] line;
  assign line = {pulse_out2_n_in, pulse_out1_n_in};
  // A low line lights the LED, so one low run is one flash.
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    for (int i = 0; i < 2; i++) begin
      if (!rst_n_in) begin
        count_out[i] <= 0;
        low_out[i] <= 0;
        run[i] <= 0;
      end else if (!line[i]) begin
        count_out[i] <= count_out[i] + int'(run[i] == 0);
        run[i] <= run[i] + 1;
      end else if (run[i] != 0) begin
        low_out[i] <= run[i];
        run[i] <= 0;
      end
    end
  end
endmodule

// *** sim/energy_pulse_output_asserts.sv ***
// Port checker for the calibration pulse block.
// Assumes one-cycle register strobes, as the port contract gives.
`timescale 1ns/1ps
module energy_pulse_output_asserts #(
  parameter int LOW_HOLD_CYCLES = 20,
  parameter int LONG_PERIOD_CYC = 40
) (
  // Clock and reset
  input wire logic        ref_clk_in,
  input wire logic        rst_n_in,
  // Register port
  input wire logic        meter_space_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  // Pulses and interrupt
  input wire logic        pulse_out1_n_out,
  input wire logic        pulse_out2_n_out,
  input wire logic        meter_irq_out,
  input wire logic [15:0] irq_vector_out
);
  logic [1:0] en_q;
  logic [1:0] off_q;
  logic       sfr_wr;
  logic       flag_wr;
  assign sfr_wr = reg_wr_in && !meter_space_in;
  assign flag_wr = sfr_wr && reg_addr_in inside {8'hda, 8'hdd};
  // Shadow bits, so the checks need no probes into the body.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_q <= 2'h0;
      off_q <= 2'h0;
    end else if (sfr_wr && reg_addr_in == 8'hda) begin
      en_q <= reg_wdata_in[7:6];
    end else if (reg_wr_in && meter_space_in && reg_addr_in == 8'h0b) begin
      off_q <= reg_wdata_in[2:1];
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  vector_fixed_a: assert property (
    irq_vector_out == 16'h004b) else $error("bad vector");
  out1_off_a: assert property (
    off_q[0] && $past(off_q[0]) |-> pulse_out1_n_out) else $error("out1 lit");
  out2_off_a: assert property (
    off_q[1] && $past(off_q[1]) |-> pulse_out2_n_out) else $error("out2 lit");
  ratio_readback_a: assert property (
    reg_wr_in && meter_space_in && reg_addr_in == 8'h27 ##1
    reg_rd_in && meter_space_in && reg_addr_in == 8'h27
    |=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("bad readback");
  irq_masked_a: assert property (
    $past(en_q) == 2'h0 |-> !meter_irq_out) else $error("irq while masked");
  irq_hold_a: assert property (
    $fell(meter_irq_out) |-> $past(flag_wr, 2)) else $error("irq dropped");
  flag1_irq_a: assert property (
    $fell(pulse_out1_n_out) && en_q[0] |=> meter_irq_out) else $error("no irq");
  flag2_irq_a: assert property (
    $fell(pulse_out2_n_out) && en_q[1] |=> meter_irq_out) else $error("no irq");
  pulse1_c: cover property ($fell(pulse_out1_n_out));
  pulse2_c: cover property ($fell(pulse_out2_n_out));
  irq_clear_c: cover property ($fell(meter_irq_out));
endmodule
bind energy_pulse_output energy_pulse_output_asserts #(
  .LOW_HOLD_CYCLES(LOW_HOLD_CYCLES), .LONG_PERIOD_CYC(LONG_PERIOD_CYC)
) asserts_inst (.ref_clk_in, .rst_n_in, .meter_space_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .pulse_out1_n_out,
  .pulse_out2_n_out, .meter_irq_out, .irq_vector_out);

// *** sim/tb.sv ***
// Self-checking bench for the calibration pulse block.
// Assumes the port contract; long pulse timings are shrunk by parameter.
`timescale 1ns/1ps
module tb;
  localparam int LOW = 20;
  localparam int LONG = 40;
  logic        clk;
  logic        rst_n;
  logic        sp;
  logic        wr;
  logic        rd;
  logic [3:0]  lsb;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] vec;
  logic        p1_n;
  logic        p2_n;
  logic        irq;
  int          cnt[2];
  int          low[2];
  int          fails = 0;
  int          checks_done = 0;
  int          cycles = 0;
  energy_pulse_output #(.LOW_HOLD_CYCLES(LOW), .LONG_PERIOD_CYC(LONG))
  energy_pulse_output_inst (.ref_clk_in(clk), .rst_n_in(rst_n),
    .active_lsb_in(lsb[0]), .reactive_lsb_in(lsb[1]),
    .apparent_lsb_in(lsb[2]), .rms_lsb_in(lsb[3]), .meter_space_in(sp),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .pulse_out1_n_out(p1_n),
    .pulse_out2_n_out(p2_n), .meter_irq_out(irq), .irq_vector_out(vec));
  cal_equipment cal_equipment_inst (.ref_clk_in(clk), .rst_n_in(rst_n),
    .pulse_out1_n_in(p1_n), .pulse_out2_n_in(p2_n), .count_out(cnt),
    .low_out(low));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // A hang is cut short well past the longest expected run.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  // Every bus task starts and ends just after a falling edge.
  // Strobes stay up between back-to-back calls; the caller drops them.
  task automatic wr_reg(input logic s, input logic [7:0] a,
                        input logic [15:0] d);
    {sp, addr, wdata, wr, rd} = {s, a, d, 2'b10};
    @(negedge clk);
  endtask
  task automatic rd_chk(input logic s, input logic [7:0] a,
                        input logic [15:0] e);
    {sp, addr, wr, rd} = {s, a, 2'b01};
    @(negedge clk);
    chk_reg(rdata, e);
  endtask
  function automatic int exp_count(int n, int d, int strobes);
    int acc = 0;
    int res = 0;
    n = (n == 0) ? 1 : n;
    d = (d == 0) ? 1 : d;
    n = (n > d) ? d : n;
    for (int i = 0; i < strobes; i++) begin
      acc += n;
      res += int'(acc >= d);
      acc -= (acc >= d) ? d : 0;
    end
    return res;
  endfunction
  task automatic run_test(input int k);
    logic [15:0] nt[4] = '{16'h0000, 16'h0003, 16'h0000, 16'hffff};
    logic [15:0] dt[4] = '{16'h0000, 16'h0002, 16'h0005, 16'hffff};
    logic [8:0]  ra[12] = '{9'h10b, 9'h10c, 9'h127, 9'h128, 9'h129,
      9'h12a, 9'h0d9, 9'h0da, 9'h0db, 9'h0dd, 9'h130, 9'h00b};
    logic [15:0] n1;
    logic [15:0] d1;
    logic [15:0] lo;
    logic [1:0]  s1;
    logic [1:0]  dis;
    logic [1:0]  en;
    logic        rms;
    logic        duty;
    int          src[4] = '{0, 0, 0, 0};
    int          gap;
    int          e[2];
    duty = (k == 4 || k == 5);
    n1 = (k < 4) ? nt[k] : 16'($urandom % 6);
    // Duty runs need a unit ratio, so each strobe fires and period is gap.
    d1 = (k < 4) ? dt[k] : duty ? n1 : 16'($urandom % 9);
    s1 = duty ? 2'h0 : 2'(k);
    rms = 1'($urandom);
    dis = (k < 6) ? 2'h0 : 2'($urandom);
    en = 2'($urandom);
    lo = 16'($urandom);
    gap = (k == 4) ? 30 : (k == 5) ? 60 : 25;
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    wr_reg(1'b1, 8'h30, 16'hffff);
    for (int i = 0; i < 12; i++) begin
      rd_chk(ra[i][8], ra[i][7:0], 16'h0000);
    end
    wr_reg(1'b1, 8'h0b, {13'h0, dis, 1'b0});
    wr_reg(1'b1, 8'h0c, {8'h0, s1 + 2'h1, s1, rms, 3'h0});
    rd_chk(1'b1, 8'h0c, {8'h0, s1 + 2'h1, s1, rms, 3'h0});
    wr_reg(1'b1, 8'h27, n1);
    rd_chk(1'b1, 8'h27, n1);
    wr_reg(1'b1, 8'h28, d1);
    wr_reg(1'b1, 8'h29, d1 + 16'h0002);
    wr_reg(1'b1, 8'h2a, n1 + 16'h0003);
    wr_reg(1'b0, 8'hda, {8'h0, en, 6'h0});
    wr_reg(1'b0, 8'hd9, lo);
    rd_chk(1'b0, 8'hd9, {8'h00, lo[7:0]});
    rd = 1'b0;
    for (int i = 0; i < 12; i++) begin
      lsb = duty ? 4'h1 : 4'($urandom);
      for (int j = 0; j < 4; j++) begin
        src[j] += int'(lsb[j]);
      end
      @(negedge clk);
      lsb = 4'h0;
      repeat (gap - 1) @(negedge clk);
    end
    e[0] = dis[0] ? 0 : exp_count(n1, d1, src[s1[1] ? 2 + rms : s1]);
    s1 = s1 + 2'h1;
    e[1] = dis[1] ? 0
      : exp_count(16'(d1 + 16'h0002), 16'(n1 + 16'h0003),
                  src[s1[1] ? 2 + rms : s1]);
    chk_cnt(cnt[0], e[0]);
    chk_cnt(cnt[1], e[1]);
    if (duty) begin
      chk_cnt(low[0], (gap >= LONG) ? LOW : gap / 2);
    end
    rd_chk(1'b0, 8'hdd, {8'h0, e[1] > 0, e[0] > 0, 6'h0});
    chk_reg({15'h0, irq}, {15'h0, |({e[1] > 0, e[0] > 0} & en)});
    chk_reg(vec, 16'h004b);
    wr_reg(1'b0, 8'hdd, 16'h0000);
    wr = 1'b0;
    @(negedge clk);
    chk_reg({15'h0, irq}, 16'h0000);
    rd_chk(1'b0, 8'hdd, 16'h0000);
    rd = 1'b0;
    $display("test %0d done", k);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    {rst_n, sp, wr, rd, lsb, addr, wdata} = '0;
    void'($urandom(32'hf503172b));
    @(negedge clk);
    for (int k = 0; k < 12; k++) begin
      run_test(k);
    end
    wrap_up();
  end
endmodule
